/* File: cycle_timer.sv */
// Loadable down-counting timer with a one-cycle done pulse.
// Assumes a load value of one or more; abort wins over start.
`timescale 1ns/1ps

module cycle_timer #(
   parameter int W = 8
) (
   input wire logic i_mclk, // System clock
   input wire logic i_rst_n, // Async reset, active low
   input wire logic i_start, // Load and run
   input wire logic i_abort, // Stop at once
   input wire logic [W-1:0] i_load, // Cycles to run
   output logic o_running, // Counting
   output logic o_done // Expiry pulse
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic run;
      logic done;
   } tmr_s;

   tmr_s q;
   tmr_s d;

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (i_abort) begin
         d.run = 1'b0;
         d.cnt = '0;
      end else if (i_start) begin
         d.run = 1'b1;
         d.cnt = i_load;
      end else if (q.run) begin
         d.cnt = q.cnt - 1'b1;
         if (q.cnt <= 1) begin
            d.run = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_running = q.run;
   assign o_done = q.done;

   // Expiry only ever follows a running count
   property p_done_after_run;
      @(posedge i_mclk) disable iff (!i_rst_n)
      q.done |-> $past(q.run) && !q.run;
   endproperty
   a_done_after_run: assert property (p_done_after_run)
      else $error("timer expired without running");

endmodule

/* File: host_pins_model.sv */
// Host model driving the convert-start and power-down pins.
// Assumes the bench calls its tasks; pins move just after a rising edge.
`timescale 1ns/1ps

module host_pins_model #(
   parameter int SETTLE_CYC = 20
) (
   input wire logic i_mclk, // System clock
   input wire logic i_busy, // Busy from the converter
   output logic o_convert_start, // Convert-start pin
   output logic o_power_down_pin // Power-down pin
);
   // ****************************************************
   // Pin timing
   // ****************************************************
   int low_cyc = 0;

   // Low time of convert-start, sets the acquisition time
   always @(posedge i_mclk) begin
      low_cyc <= o_convert_start ? 0 : low_cyc + 1;
   end

   initial begin
      o_convert_start = 1'b0;
      o_power_down_pin = 1'b0;
   end

   // Wait out power-on initialisation and reference settling.
   // Scaled down to the bench's short init count; real parts need ms.
   task automatic settle;
      repeat (SETTLE_CYC) @(posedge i_mclk);
   endtask

   // Two-cycle pulse; 50 ns keeps disturbance out of the conversion
   task automatic convert(input bit keep_rules);
      for (int k = 0; k < 200 && keep_rules && (i_busy || low_cyc < 16); k++) begin
         @(posedge i_mclk);
      end
      @(posedge i_mclk);
      o_convert_start <= 1'b1;
      repeat (2) @(posedge i_mclk);
      o_convert_start <= 1'b0;
   endtask

   // Power-down level; after lowering, no request until settled
   task automatic set_pd(input logic v);
      @(posedge i_mclk);
      o_power_down_pin <= v;
      if (!v) begin
         settle();
      end
   endtask
endmodule

/* File: sar_conversion_control.sv */
// Conversion sequencing and power-state control of a four-channel
// simultaneous-sampling converter, with a small register port.
// Assumes convert_start, power_down_pin and the select pin are
// synchronous to i_mclk; the analog core supplies i_result_data.
//
// Overview of operation
// - Convert-start rise samples all channels, starts conversion
// - Running conversion ends only by completion or reset
// - Busy high from start until conversion ends
// - Conversion lasts at most 525 N minus 20 ns
// - Power-down high: powered down, requests ignored
// - Power-down during conversion waits for its completion
// - Second power-down rise without conversion: global reset
// - Global reset ends itself on internal timer
// - Global reset clears results, ranges to code 7
// - Global reset halts a running conversion immediately
// - Reset leaves power-down behaviour unchanged
// - Nap after each conversion, wake on convert-start
// - Select pin picks CMOS or LVDS, CMOS lanes 1-4
// - Range register resets to all ones
// - Range code zero disables channel, shortens conversion
`timescale 1ns/1ps
`include "sar_ctrl_consts.svh"

module sar_conversion_control #(
   parameter int INIT_CYCLES = `INIT_CYCLES_DEF,
   parameter int GRST_CYCLES = `GRST_CYCLES_DEF
) (
   input wire logic i_mclk, // 40 MHz clock
   input wire logic i_rst_n, // Power-on reset, active low
   input wire logic i_convert_start, // Convert-start pin
   input wire logic i_power_down_pin, // Power-down pin
   input wire logic i_lvds_sel, // Interface select pin, 1 = LVDS
   input wire logic [63:0] i_result_data, // Core results, ch0 low
   input wire logic [7:0] i_addr, // Register byte address
   input wire logic [31:0] i_wdata, // Register write data
   input wire logic i_wr, // Write strobe
   input wire logic i_rd, // Read strobe
   output logic [31:0] o_rdata, // Read data, cycle after strobe
   output logic o_busy, // Conversion in progress
   output logic o_sample_hold, // All sample-and-holds holding
   output logic o_powered_down, // Powered down
   output logic o_nap, // Napping between conversions
   output logic o_reset_active, // Global reset running
   output logic o_init_pending, // Initialization wait running
   output logic o_lvds_mode, // LVDS interface selected
   output logic [3:0] o_lane_en, // Serial lanes enabled
   output logic [11:0] o_range_cfg // Range codes, ch0 low
);

   localparam int CONV_W = 7;
   localparam int GRST_W = 8;
   localparam int INIT_W = 19;

   sar_ctrl_pkg::ctl_s q;
   sar_ctrl_pkg::ctl_s d;

   logic cnv_rise;
   logic pd_rise;
   logic pd_fall;
   logic grst_fire;
   logic conv_start;
   logic conv_done;
   logic conv_run;
   logic grst_done;
   logic grst_run;
   logic init_start;
   logic init_run;
   logic [2:0] nch_now;
   logic [CONV_W-1:0] conv_load_v;
   logic [31:0] status_w;

   // ****************************************************
   // Helpers
   // ****************************************************

   // Enabled channels: any range code other than off
   function automatic logic [2:0] count_enabled(input logic [`RANGE_W-1:0] r);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < `NUM_CH; i++) begin
         if (r[i*`CODE_W +: `CODE_W] != `CODE_OFF) begin
            n = n + 3'h1;
         end
      end
      return n;
   endfunction

   // Timer load for n channels, rounded down to whole cycles.
   // Busy also stays high in the done-pulse cycle, so the load is one less.
   function automatic logic [CONV_W-1:0] conv_load(input logic [2:0] n);
      int cyc;
      cyc = (`CONV_NS_PER_CH * int'(n) - `CONV_NS_OFFSET) / `CLK_PERIOD_NS;
      if (n == 3'h0 || cyc < 2) begin
         return 7'h01;
      end
      return CONV_W'(cyc - 1);
   endfunction

   // ****************************************************
   // Pin events
   // ****************************************************

   // Edge detects on the host pins
   assign cnv_rise = i_convert_start & ~q.cnv_prev;
   assign pd_rise = i_power_down_pin & ~q.pd_prev;
   assign pd_fall = ~i_power_down_pin & q.pd_prev;

   // Second power-down rise with no conversion since the first
   assign grst_fire = pd_rise & q.pd_armed & (q.state != sar_ctrl_pkg::ST_GRST);

   // Start only from idle, never while powered down or in reset
   assign conv_start = cnv_rise & (q.state == sar_ctrl_pkg::ST_IDLE)
                       & ~i_power_down_pin & ~grst_fire;

   // Channel count from the range codes in force at the edge
   assign nch_now = count_enabled(q.range);
   assign conv_load_v = conv_load(nch_now);

   // Init wait restarts after power-on, power-down exit, global reset
   assign init_start = q.por_kick | pd_fall | grst_done;

   // ****************************************************
   // Timers
   // ****************************************************

   // Conversion clock; only the global reset may cut it short
   cycle_timer #(
      .W(CONV_W)
   ) u_conv_timer (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_start(conv_start),
      .i_abort(grst_fire),
      .i_load(conv_load_v),
      .o_running(conv_run),
      .o_done(conv_done)
   );

   // Global reset duration, self-timed
   cycle_timer #(
      .W(GRST_W)
   ) u_grst_timer (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_start(grst_fire),
      .i_abort(1'b0),
      .i_load(GRST_W'(GRST_CYCLES)),
      .o_running(grst_run),
      .o_done(grst_done)
   );

   // Initialization wait shown to software; it blocks nothing
   cycle_timer #(
      .W(INIT_W)
   ) u_init_timer (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_start(init_start),
      .i_abort(1'b0),
      .i_load(INIT_W'(INIT_CYCLES)),
      .o_running(init_run),
      .o_done()
   );

   // ****************************************************
   // Status word
   // ****************************************************
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[`STB_BUSY] = q.busy;
      status_w[`STB_PDOWN] = q.pdown;
      status_w[`STB_NAP] = q.nap;
      status_w[`STB_GRST] = q.grst;
      status_w[`STB_INIT] = init_run;
      status_w[`STB_LVDS] = q.lvds;
      status_w[`STB_NCH_LO +: 3] = q.nch;
   end

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      d = q;
      d.cnv_prev = i_convert_start;
      d.pd_prev = i_power_down_pin;
      d.por_kick = 1'b0;
      d.lvds = i_lvds_sel;
      // All four lanes are offered in CMOS mode; host uses 1 to 4
      d.lane_en = i_lvds_sel ? 4'h1 : 4'hf;

      // Any power-down rise arms the double-pulse reset
      if (pd_rise) begin
         d.pd_armed = 1'b1;
      end

      unique case (q.state)
         sar_ctrl_pkg::ST_IDLE: begin
            if (i_power_down_pin) begin
               d.state = sar_ctrl_pkg::ST_PDOWN;
               d.pdown = 1'b1;
               d.nap = 1'b0;
            end else if (conv_start) begin
               d.state = sar_ctrl_pkg::ST_CONV;
               d.busy = 1'b1;
               d.hold = 1'b1;
               d.nap = 1'b0;
               d.nch = nch_now;
               d.pd_armed = 1'b0;
            end
         end
         sar_ctrl_pkg::ST_CONV: begin
            // Power-down is noted but the conversion runs on
            if (conv_done) begin
               d.busy = 1'b0;
               d.hold = 1'b0;
               d.res = i_result_data;
               if (i_power_down_pin) begin
                  d.state = sar_ctrl_pkg::ST_PDOWN;
                  d.pdown = 1'b1;
               end else begin
                  d.state = sar_ctrl_pkg::ST_IDLE;
                  d.nap = 1'b1;
               end
            end
         end
         sar_ctrl_pkg::ST_PDOWN: begin
            // Convert-start edges are dropped here
            if (!i_power_down_pin) begin
               d.state = sar_ctrl_pkg::ST_IDLE;
               d.pdown = 1'b0;
               d.nap = 1'b1;
            end
         end
         sar_ctrl_pkg::ST_GRST: begin
            // Power-down still follows the pin during reset
            d.pdown = i_power_down_pin;
            if (grst_done) begin
               d.grst = 1'b0;
               if (i_power_down_pin) begin
                  d.state = sar_ctrl_pkg::ST_PDOWN;
               end else begin
                  d.state = sar_ctrl_pkg::ST_IDLE;
                  d.nap = 1'b1;
               end
            end
         end
      endcase

      // Range word written by software
      if (i_wr && i_addr == `ADDR_RANGE) begin
         d.range = i_wdata[`RANGE_W-1:0];
      end

      // Global reset overrides everything, including a write this cycle
      if (grst_fire) begin
         d.state = sar_ctrl_pkg::ST_GRST;
         d.grst = 1'b1;
         d.busy = 1'b0;
         d.hold = 1'b0;
         d.nap = 1'b0;
         d.pd_armed = 1'b0;
         d.pdown = 1'b1;
         d.res = '0;
         d.range = `RANGE_RST;
      end

      // Read data stand for one cycle only
      d.rdata = 32'h0000_0000;
      if (i_rd) begin
         unique case (i_addr)
            `ADDR_RANGE: d.rdata = {20'h0_0000, q.range};
            `ADDR_STATUS: d.rdata = status_w;
            `ADDR_RES0: d.rdata = {16'h0000, q.res[0*`RES_W +: `RES_W]};
            `ADDR_RES1: d.rdata = {16'h0000, q.res[1*`RES_W +: `RES_W]};
            `ADDR_RES2: d.rdata = {16'h0000, q.res[2*`RES_W +: `RES_W]};
            `ADDR_RES3: d.rdata = {16'h0000, q.res[3*`RES_W +: `RES_W]};
            default: d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************
   // State register
   // ****************************************************

   // Range codes come up all ones, every channel in code 7
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
         q.state <= sar_ctrl_pkg::ST_IDLE;
         q.por_kick <= 1'b1;
         q.range <= `RANGE_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state flops
   assign o_rdata = q.rdata;
   assign o_busy = q.busy;
   assign o_sample_hold = q.hold;
   assign o_powered_down = q.pdown;
   assign o_nap = q.nap;
   assign o_reset_active = q.grst;
   assign o_init_pending = init_run;
   assign o_lvds_mode = q.lvds;
   assign o_lane_en = q.lane_en;
   assign o_range_cfg = q.range;

   // ****************************************************
   // Checks
   // ****************************************************

   property p_start_holds;
      @(posedge i_mclk) disable iff (!i_rst_n)
      conv_start |=> o_busy && o_sample_hold;
   endproperty
   a_start_holds: assert property (p_start_holds)
      else $error("conversion start did not raise busy and hold");

   property p_busy_ends;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $fell(o_busy) |-> $past(conv_done) || $past(grst_fire);
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("busy fell without completion or reset");

   property p_busy_hold;
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_busy |-> o_sample_hold && (conv_run || conv_done);
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy high without a running conversion");

   property p_conv_max;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_busy) |-> ##[1:83] !o_busy;
   endproperty
   a_conv_max: assert property (p_conv_max)
      else $error("conversion longer than allowed");

   property p_pd_ignore;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_power_down_pin && !o_busy) |=> !o_busy;
   endproperty
   a_pd_ignore: assert property (p_pd_ignore)
      else $error("conversion started while powered down");

   property p_pd_after_conv;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (conv_done && i_power_down_pin && !grst_fire) |=> o_powered_down && !o_busy;
   endproperty
   a_pd_after_conv: assert property (p_pd_after_conv)
      else $error("no power-down after conversion completed");

   property p_grst;
      @(posedge i_mclk) disable iff (!i_rst_n)
      grst_fire |=> o_reset_active && !o_busy && o_range_cfg == `RANGE_RST
                    && q.res == '0;
   endproperty
   a_grst: assert property (p_grst)
      else $error("global reset did not clear state");

   property p_grst_end;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_reset_active) |-> o_reset_active[*2] ##[0:300] !o_reset_active;
   endproperty
   a_grst_end: assert property (p_grst_end)
      else $error("global reset did not end on its own");

   property p_grst_pd;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (o_reset_active && $past(o_reset_active)) |-> o_powered_down == $past(i_power_down_pin);
   endproperty
   a_grst_pd: assert property (p_grst_pd)
      else $error("power-down lost during global reset");

   property p_nap;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (conv_done && !i_power_down_pin && !grst_fire) |=> o_nap ##1 (o_nap || o_busy
         || o_powered_down || o_reset_active);
   endproperty
   a_nap: assert property (p_nap)
      else $error("no nap after conversion");

   property p_count;
      @(posedge i_mclk) disable iff (!i_rst_n)
      conv_start |=> q.nch == $past(nch_now);
   endproperty
   a_count: assert property (p_count)
      else $error("channel count not frozen at start");

   property p_lanes;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $past(i_rst_n) |-> o_lvds_mode == $past(i_lvds_sel) && (o_lvds_mode || o_lane_en == 4'hf);
   endproperty
   a_lanes: assert property (p_lanes)
      else $error("interface select not followed");

endmodule

/* File: sar_ctrl_consts.svh */
// Constants of the conversion and power-state controller.
// Assumes inclusion by bare name; definitions only, no logic.
`ifndef SAR_CTRL_CONSTS_SVH
`define SAR_CTRL_CONSTS_SVH

// ****************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************
`define ADDR_RANGE 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_RES0 8'h08
`define ADDR_RES1 8'h0c
`define ADDR_RES2 8'h10
`define ADDR_RES3 8'h14

// ****************************************************
// Field positions and reset values
// ****************************************************
`define NUM_CH 4
`define CODE_W 3
`define RANGE_W 12
`define RES_W 16
`define RANGE_RST 12'hfff
`define CODE_OFF 3'h0
`define STB_BUSY 0
`define STB_PDOWN 1
`define STB_NAP 2
`define STB_GRST 3
`define STB_INIT 4
`define STB_LVDS 5
`define STB_NCH_LO 8

// ****************************************************
// Timing
// ****************************************************
`define CLK_PERIOD_NS 25
`define CONV_NS_PER_CH 525
`define CONV_NS_OFFSET 20
`define INIT_MS 10
`define INIT_CYCLES_DEF (`INIT_MS * 1000000 / `CLK_PERIOD_NS)
`define GRST_CYCLES_DEF 16

`endif

/* File: sar_ctrl_pkg.sv */
// Types shared by the conversion controller.
// Assumes sar_ctrl_consts.svh is on the include path.
`include "sar_ctrl_consts.svh"

package sar_ctrl_pkg;

   // Controller states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV,
      ST_PDOWN,
      ST_GRST
   } ctl_state_e;

   // Complete state of the controller
   typedef struct packed {
      ctl_state_e state;
      logic cnv_prev;
      logic pd_prev;
      logic pd_armed;
      logic por_kick;
      logic busy;
      logic hold;
      logic pdown;
      logic nap;
      logic grst;
      logic lvds;
      logic [3:0] lane_en;
      logic [2:0] nch;
      logic [`RANGE_W-1:0] range;
      logic [`NUM_CH*`RES_W-1:0] res;
      logic [31:0] rdata;
   } ctl_s;

endpackage

/* File: tb_sar_conversion_control.sv */
// Self-checking bench of the conversion and power-state controller.
// Assumes the host model file and the design constants header.
`timescale 1ns/1ps
`include "sar_ctrl_consts.svh"

module tb_sar_conversion_control;
   // ****************************************************
   // Signals and instances
   // ****************************************************
   localparam int GRST = 16;
   logic i_mclk;
   logic i_rst_n;
   logic i_lvds_sel;
   logic [63:0] i_result_data;
   logic [7:0] i_addr;
   logic [31:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [31:0] o_rdata;
   logic o_busy, o_sample_hold, o_powered_down, o_nap;
   logic o_reset_active, o_init_pending, o_lvds_mode;
   logic [3:0] o_lane_en;
   logic [11:0] o_range_cfg;
   logic convert_start, pd;
   int n_errors = 0;
   int n_checks = 0;
   int run = 0;
   int last_len = 0;

   sar_conversion_control #(
      .INIT_CYCLES(20),
      .GRST_CYCLES(GRST)
   ) DUT (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_convert_start(convert_start),
      .i_power_down_pin(pd),
      .i_lvds_sel(i_lvds_sel),
      .i_result_data(i_result_data),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .o_busy(o_busy),
      .o_sample_hold(o_sample_hold),
      .o_powered_down(o_powered_down),
      .o_nap(o_nap),
      .o_reset_active(o_reset_active),
      .o_init_pending(o_init_pending),
      .o_lvds_mode(o_lvds_mode),
      .o_lane_en(o_lane_en),
      .o_range_cfg(o_range_cfg)
   );

   host_pins_model #(
      .SETTLE_CYC(20)
   ) HOST (
      .i_mclk(i_mclk),
      .i_busy(o_busy),
      .o_convert_start(convert_start),
      .o_power_down_pin(pd)
   );

   // Clock at 40 MHz
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   // Busy run length of the last finished conversion
   always @(posedge i_mclk) begin
      if (o_busy === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         last_len <= run;
         run <= 0;
      end
   end

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   task automatic wait_idle;
      int k;
      for (k = 0; k < 300 && o_busy !== 1'b0; k++) begin
         @(posedge i_mclk);
         #1;
      end
      if (k == 300) begin
         n_errors++;
         wrap_up();
      end
      @(posedge i_mclk);
      #1;
   endtask

   task automatic conv_len(input int exp_len, input logic [2:0] exp_n);
      logic [31:0] d;
      HOST.convert(1'b1);
      wait_idle();
      chk("busy length", exp_len, last_len);
      rd(`ADDR_STATUS, d);
      chk("channel count", {29'h0, exp_n}, {29'h0, d[10:8]});
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic s_reset;
      logic [31:0] d;
      chk("init done", 32'h0, {31'h0, o_init_pending});
      chk("range port", 32'h0000_0fff, {20'h0, o_range_cfg});
      rd(`ADDR_RANGE, d);
      chk("range reg", 32'h0000_0fff, d);
      rd(8'h20, d);
      chk("unmapped", 32'h0000_0000, d);
   endtask

   task automatic s_basic;
      logic [31:0] d;
      HOST.convert(1'b1);
      #1 chk("hold", 32'h1, {31'h0, o_sample_hold});
      chk("nap awake", 32'h0, {31'h0, o_nap});
      HOST.convert(1'b0);
      wr(`ADDR_RANGE, 32'h0000_0000);
      wait_idle();
      chk("busy length", 83, last_len);
      chk("nap after", 32'h1, {31'h0, o_nap});
      rd(`ADDR_RES2, d);
      chk("result ch2", 32'h0000_3333, d);
   endtask

   // Channel count follows the codes; code zero drops a channel
   task automatic s_ranges;
      logic [11:0] cfg[5] = '{12'h007, 12'h808, 12'h1ff, 12'h000, 12'hfff};
      int len[5] = '{20, 41, 62, 2, 83};
      logic [2:0] n[5] = '{3'd1, 3'd2, 3'd3, 3'd0, 3'd4};
      for (int i = 0; i < 5; i++) begin
         wr(`ADDR_RANGE, {20'h0, cfg[i]});
         conv_len(len[i], n[i]);
      end
   endtask

   task automatic s_pdown;
      HOST.set_pd(1'b1);
      @(posedge i_mclk);
      #1 chk("powered down", 32'h1, {31'h0, o_powered_down});
      HOST.convert(1'b0);
      repeat (3) @(posedge i_mclk);
      #1 chk("request ignored", 32'h0, {31'h0, o_busy});
      HOST.set_pd(1'b0);
      chk("powered up", 32'h0, {31'h0, o_powered_down});
      chk("init restarted", 32'h1, {31'h0, o_init_pending});
      conv_len(83, 3'd4);
      HOST.convert(1'b1);
      HOST.set_pd(1'b1);
      wait_idle();
      chk("busy length", 83, last_len);
      chk("down after", 32'h1, {31'h0, o_powered_down});
      HOST.set_pd(1'b0);
      conv_len(83, 3'd4);
   endtask

   task automatic s_grst;
      logic [31:0] d;
      HOST.set_pd(1'b1);
      HOST.set_pd(1'b0);
      wr(`ADDR_RANGE, 32'h0000_0000);
      HOST.set_pd(1'b1);
      @(posedge i_mclk);
      #1 chk("reset active", 32'h1, {31'h0, o_reset_active});
      chk("range restored", 32'h0000_0fff, {20'h0, o_range_cfg});
      repeat (GRST - 2) @(posedge i_mclk);
      #1 chk("reset held", 32'h1, {31'h0, o_reset_active});
      repeat (3) @(posedge i_mclk);
      #1 chk("reset ended", 32'h0, {31'h0, o_reset_active});
      chk("still down", 32'h1, {31'h0, o_powered_down});
      rd(`ADDR_RES0, d);
      chk("result cleared", 32'h0000_0000, d);
      @(posedge i_mclk);
      i_result_data <= 64'h8888_7777_6666_5555;
      HOST.set_pd(1'b0);
      conv_len(83, 3'd4);
      rd(`ADDR_RES3, d);
      chk("result ch3", 32'h0000_8888, d);
      HOST.convert(1'b1);
      HOST.set_pd(1'b1);
      HOST.set_pd(1'b0);
      HOST.set_pd(1'b1);
      wait_idle();
      chk("halted early", 32'h1, {31'h0, last_len < 82});
      HOST.set_pd(1'b0);
   endtask

   task automatic s_lvds;
      @(posedge i_mclk);
      i_lvds_sel <= 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 chk("lvds lanes", 32'h0000_0011, {27'h0, o_lvds_mode, o_lane_en});
      @(posedge i_mclk);
      i_lvds_sel <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1 chk("cmos lanes", 32'h0000_000f, {27'h0, o_lvds_mode, o_lane_en});
   endtask

   // ****************************************************
   // Main sequence and hang guard
   // ****************************************************
   initial begin
      i_rst_n <= 1'b0;
      i_lvds_sel <= 1'b0;
      i_result_data <= 64'h4444_3333_2222_1111;
      i_addr <= 8'h00;
      i_wdata <= 32'h0000_0000;
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (4) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 chk("init pending", 32'h1, {31'h0, o_init_pending});
      HOST.settle();
      s_reset();
      s_basic();
      s_ranges();
      s_pdown();
      s_grst();
      s_lvds();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge i_mclk);
      n_errors++;
      wrap_up();
   end
endmodule
